// >>> inc/wdt_pkg.sv
// constants for the watchdog timer unit: register map, fields, codes, timing
// assumes a 100 MHz mclk and an avalon-mm register bus with 32-bit data
package wdt_pkg;
   // byte addresses on the register bus
   localparam logic [15:0] ADDR_CTRL_ONE  = 16'h0034;
   localparam logic [15:0] ADDR_COMMAND   = 16'h0038;
   localparam logic [15:0] ADDR_STATUS    = 16'h003C;
   localparam logic [15:0] ADDR_CONFIG    = 16'h0040;
   // watchdog_control_one fields
   localparam int          CTRL_ENABLE_BIT = 3;
   localparam int          CTRL_PERIOD_LSB = 1;
   localparam int          CTRL_ACTION_BIT = 0;
   // status fields
   localparam int          STAT_CNT_LSB    = 0;
   localparam int          STAT_ACTIVE_BIT = 2;
   localparam int          STAT_ACTION_BIT = 3;
   localparam int          STAT_ENABLE_BIT = 4;
   localparam int          STAT_OVF_BIT    = 5;
   localparam int          STAT_PERIOD_LSB = 6;
   // config fields
   localparam int          CFG_DIVSEL_BIT  = 0;
   // command codes
   localparam logic [7:0]  CODE_CLEAR      = 8'h4E;
   localparam logic [7:0]  CODE_DISABLE    = 8'hB1;
   // reset values
   localparam logic        RST_ENABLE      = 1'b1;
   localparam logic [1:0]  RST_PERIOD      = 2'h0;
   localparam logic        RST_ACTION      = 1'b1;
   localparam logic        RST_DIVSEL      = 1'b0;
   // timing: overflow period is 2^(base - 2*code + divsel) clocks
   localparam int          PERIOD_LOG2_MAX = 25;
   localparam int          PERIOD_STEP     = 2;
   localparam int          CNT_STAGES_LOG2 = 2;
   localparam int          DIV_W           = 26;
   // reset pulse: at most 24 high-frequency clocks
   localparam int          RESET_MAX_CLKS  = 24;
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          RESET_MAX_NS    = RESET_MAX_CLKS * CLK_PERIOD_NS;
   localparam int          RESET_CYCLES    = RESET_MAX_NS / CLK_PERIOD_NS;
   localparam logic [4:0]  RESET_LEN       = 5'(RESET_CYCLES);
endpackage : wdt_pkg

// >>> tb/watchdog_timer_unit_bench.sv
// self-checking bench for the watchdog timer unit: avalon-mm register tasks
// assumes wdt_pkg is compiled first; divider shortened through PERIOD_LOG2_BASE
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_unit_bench;
   import wdt_pkg::*;
   localparam int BASE = 9;
   logic        mclk;
   logic        rst_n;
   logic [15:0] address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        stop_mode;
   logic        idle_mode;
   logic        wd_reset_req;
   logic        wd_overflow_irq;
   logic [7:0]  rd;
   logic [7:0]  held;
   int          error_cnt = 0;
   int          n_checks  = 0;
   int          irq_seen  = 0;
   int          rst_cyc   = 0;
   int          gap;
   int          c0;

   watchdog_timer_unit #(.PERIOD_LOG2_BASE(BASE)) u_watchdog_timer_unit (
      .mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .stop_mode(stop_mode), .idle_mode(idle_mode),
      .wd_reset_req(wd_reset_req), .wd_overflow_irq(wd_overflow_irq));

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // event counters let a test prove that nothing fired in a window
   always @(posedge mclk) begin
      if (wd_overflow_irq === 1'b1) irq_seen <= irq_seen + 1;
      if (wd_reset_req === 1'b1) rst_cyc <= rst_cyc + 1;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string m);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp, input string m);
      n_checks++;
      if (got != exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask : chk_n

   // one request held until waitrequest is sampled low, then one idle edge
   task automatic bus(input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      address    <= a;
      read       <= ~wr;
      write      <= wr;
      writedata  <= {24'h00_0000, d};
      byteenable <= 4'hF;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata[7:0];
      if (n >= 50) chk_n(n, 0, "bus answer timeout");
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic st(input logic [7:0] mask, input logic [7:0] exp,
                     input string m);
      bus(1'b0, ADDR_STATUS, 8'h00);
      chk(rd & mask, exp, m);
   endtask : st

   task automatic wait_hi(input bit rs, input int lim, output int dt);
      dt = 0;
      do begin
         @(posedge mclk);
         dt++;
      end while ((rs ? wd_reset_req : wd_overflow_irq) !== 1'b1 && dt <= lim);
      if (dt > lim) chk_n(dt, lim, "overflow output never rose");
   endtask : wait_hi

   initial begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      $display("mismatch at %0t: watchdog timeout", $time);
      complete_run();
   end

   initial begin
      rst_n = 1'b0;
      address = 16'h0000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
      stop_mode = 1'b0;
      idle_mode = 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      st(8'hFF, 8'h1C, "status after reset");
      bus(1'b0, ADDR_CTRL_ONE, 8'h00);
      chk(rd, 8'h00, "ctrl read");
      bus(1'b0, ADDR_COMMAND, 8'h00);
      chk(rd, 8'h00, "cmd read");
      bus(1'b0, 16'h0050, 8'h00);
      chk(rd, 8'h00, "unmapped read");
      $display("test reset values done");
      // default reset action: one 24-clock request, no interrupt
      wait_hi(1'b1, 700, gap);
      gap = 1;
      while (wd_reset_req === 1'b1 && gap < 60) begin
         @(posedge mclk);
         if (wd_reset_req === 1'b1) gap++;
      end
      chk_n(gap, RESET_MAX_CLKS, "reset request length");
      chk_n(irq_seen, 0, "irq in reset mode");
      $display("test reset overflow done");
      // clears land 374 clocks apart, just under 3/4 of the period, at a
      // phase where the kept divider brings the next overflow in early
      repeat (70) @(posedge mclk);
      c0 = rst_cyc;
      repeat (3) begin
         bus(1'b1, ADDR_COMMAND, CODE_CLEAR);
         repeat (371) @(posedge mclk);
      end
      bus(1'b1, ADDR_COMMAND, CODE_CLEAR);
      chk_n(rst_cyc - c0, 0, "overflow despite clears");
      wait_hi(1'b1, 600, gap);
      // a cleared divider would give a full 512-clock wait
      chk_n(int'(gap > 425 && gap < 475), 1, "short first overflow");
      st(8'h23, 8'h20, "overflow flag set");
      bus(1'b1, ADDR_COMMAND, CODE_CLEAR);
      st(8'h23, 8'h00, "clear code");
      // the reset request must run out before the irq-mode count starts
      repeat (30) @(posedge mclk);
      $display("test clear code done");
      c0 = rst_cyc;
      bus(1'b1, ADDR_CTRL_ONE, 8'h08);
      bus(1'b1, ADDR_CTRL_ONE, 8'h09);
      st(8'hDC, 8'h14, "action stays irq");
      wait_hi(1'b0, 1100, gap);
      @(posedge mclk);
      chk({7'h00, wd_overflow_irq}, 8'h00, "irq pulse width");
      for (int d = 0; d < 2; d++) begin
         for (int p = 0; p < 4; p++) begin
            bus(1'b1, ADDR_CONFIG, 8'(d));
            bus(1'b1, ADDR_CTRL_ONE, 8'(8 | (p << 1)));
            wait_hi(1'b0, 2200, gap);
            wait_hi(1'b0, 2200, gap);
            chk_n(gap, 1 << (BASE - 2 * p + d), "irq period");
         end
      end
      chk_n(rst_cyc - c0, 0, "reset request in irq mode");
      $display("test irq periods done");
      for (int m = 0; m < 2; m++) begin
         // the counter is cleared before stop and again right after it
         if (m == 1)
            bus(1'b1, ADDR_COMMAND, CODE_CLEAR);
         if (m == 0)
            idle_mode <= 1'b1;
         else
            stop_mode <= 1'b1;
         @(posedge mclk);
         c0 = irq_seen;
         bus(1'b0, ADDR_STATUS, 8'h00);
         held = rd & 8'h03;
         repeat (60) @(posedge mclk);
         st(8'h03, held, "count held in low power");
         chk_n(irq_seen - c0, 0, "irq while paused");
         idle_mode <= 1'b0;
         stop_mode <= 1'b0;
         if (m == 1)
            bus(1'b1, ADDR_COMMAND, CODE_CLEAR);
         wait_hi(1'b0, 40, gap);
      end
      $display("test low power done");
      bus(1'b1, ADDR_COMMAND, CODE_DISABLE);
      st(8'h04, 8'h04, "disable while enabled");
      bus(1'b1, ADDR_COMMAND, CODE_CLEAR);
      bus(1'b1, ADDR_CTRL_ONE, 8'h06);
      st(8'h04, 8'h04, "enable 0 alone");
      bus(1'b1, ADDR_COMMAND, 8'h5A);
      st(8'h04, 8'h04, "other command");
      bus(1'b1, ADDR_COMMAND, CODE_DISABLE);
      // a pulse launched as the disable lands is still being counted
      repeat (2) @(posedge mclk);
      c0 = irq_seen;
      repeat (100) @(posedge mclk);
      st(8'h07, 8'h00, "disabled and cleared");
      chk_n(irq_seen - c0, 0, "irq while disabled");
      bus(1'b1, ADDR_CTRL_ONE, 8'h0E);
      st(8'h14, 8'h14, "re-enabled");
      wait_hi(1'b0, 60, gap);
      $display("test disable done");
      // a mid-run reset brings back the reset action and a running counter
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      st(8'hFF, 8'h1C, "status after second reset");
      $display("test second reset done");
      complete_run();
   end
endmodule : watchdog_timer_unit_bench
`default_nettype wire

// >>> verilog/watchdog_timer_unit.sv
// watchdog timer unit: free-running divider, two-stage binary counter,
// reset or nmi on overflow, avalon-mm register slave
// assumes stop_mode and idle_mode come from logic on mclk
//
// How it works
// - action select is programmable once; it comes out of reset as reset action
// - after action select is written 0, writes of 1 are ignored until reset
// - enable bit resets to 1; counting starts right after reset release
// - overflow with action select 1 drives a hardware reset request
// - overflow with action select 0 raises the watchdog interrupt instead
// - counting holds in stop and idle, resumes from held value
// - clear code clears the binary counter and the overflow flag, never the free divider
// - period codes 00..11 give 2^25..2^19 clocks, doubled by divider select
// - writing enable 0 alone does not stop; disable code must follow
// - disable code counts only while the enable bit is 0
// - while disabled the binary counter is held cleared
// - both control registers are write-only; reads return zero here
// - the watchdog interrupt is not gated by the interrupt master flag
// - every overflow with action select 0 issues a fresh interrupt pulse even while one is served
// - the overflow reset request lasts no longer than 24 clocks
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_unit #(
   parameter int PERIOD_LOG2_BASE = wdt_pkg::PERIOD_LOG2_MAX
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [15:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // low-power modes
   input  wire logic        stop_mode,
   input  wire logic        idle_mode,
   // overflow actions
   output var  logic        wd_reset_req,
   output var  logic        wd_overflow_irq
);
   import wdt_pkg::*;

   // tick when the divider tap below the selected quarter period wraps
   function automatic logic tap_wrap(input logic [DIV_W-1:0] d,
                                     input int unsigned       k);
      logic [DIV_W-1:0] mask;
      mask = DIV_W'((64'h1 << (k + 1)) - 64'h1);
      return (d & mask) == mask;
   endfunction : tap_wrap

   function automatic int unsigned tap_bit(input logic [1:0] code,
                                           input logic       dsel);
      return PERIOD_LOG2_BASE - PERIOD_STEP * int'(code)
             + int'(dsel) - CNT_STAGES_LOG2 - 1;
   endfunction : tap_bit

   // bus state
   logic             ack;
   logic             next_ack;
   logic [31:0]      next_readdata;
   logic             next_waitrequest;
   // watchdog state
   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] next_div;
   logic [1:0]       cnt;
   logic [1:0]       next_cnt;
   logic             enable_bit;
   logic             next_enable_bit;
   logic [1:0]       period;
   logic [1:0]       next_period;
   logic             action;
   logic             next_action;
   logic             divsel;
   logic             next_divsel;
   logic             active;
   logic             next_active;
   logic             ovf_seen;
   logic             next_ovf_seen;
   logic [4:0]       rst_len;
   logic [4:0]       next_rst_len;
   logic             next_wd_reset_req;
   logic             next_wd_overflow_irq;
   // decode
   logic             wr_take;
   logic             wr_ctrl;
   logic             wr_cmd;
   logic             wr_cfg;
   logic             paused;
   logic             tick;
   logic             overflow;
   logic [7:0]       wbyte;

   // a write lands at the edge where the master sees waitrequest low
   assign wr_take  = write & ack & byteenable[0];
   assign wbyte    = writedata[7:0];
   assign wr_ctrl  = wr_take & (address == ADDR_CTRL_ONE);
   assign wr_cmd   = wr_take & (address == ADDR_COMMAND);
   assign wr_cfg   = wr_take & (address == ADDR_CONFIG);
   assign paused   = stop_mode | idle_mode;
   assign tick     = tap_wrap(div, tap_bit(period, divsel));
   assign overflow = active & ~paused & tick & (cnt == 2'h3);

   // one wait state, then a one-cycle answer
   always_comb begin
      next_ack         = (read | write) & ~ack;
      next_waitrequest = ~next_ack;
      next_readdata    = 32'h0000_0000;
      if (read & ~ack) begin
         unique case (address)
            ADDR_STATUS: begin
               next_readdata[STAT_CNT_LSB +: 2]    = cnt;
               next_readdata[STAT_ACTIVE_BIT]      = active;
               next_readdata[STAT_ACTION_BIT]      = action;
               next_readdata[STAT_ENABLE_BIT]      = enable_bit;
               next_readdata[STAT_OVF_BIT]         = ovf_seen;
               next_readdata[STAT_PERIOD_LSB +: 2] = period;
            end
            ADDR_CONFIG: begin
               next_readdata[CFG_DIVSEL_BIT] = divsel;
            end
            // control registers are write-only; they read as zero
            default: next_readdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack         <= 1'b0;
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else begin
         ack         <= next_ack;
         waitrequest <= next_waitrequest;
         readdata    <= next_readdata;
      end
   end

   always_comb begin
      next_div             = DIV_W'(div + 1'b1);
      next_cnt             = cnt;
      next_enable_bit      = enable_bit;
      next_period          = period;
      next_action          = action;
      next_divsel          = divsel;
      next_active          = active;
      next_ovf_seen        = ovf_seen;
      next_wd_overflow_irq = 1'b0;
      next_rst_len         = (rst_len != 5'h00) ? 5'(rst_len - 1'b1) : 5'h00;
      if (wr_ctrl) begin
         next_enable_bit = wbyte[CTRL_ENABLE_BIT];
         next_period     = wbyte[CTRL_PERIOD_LSB +: 2];
         next_action     = action & wbyte[CTRL_ACTION_BIT];
         if (wbyte[CTRL_ENABLE_BIT])
            next_active = 1'b1;
      end
      if (wr_cfg)
         next_divsel = wbyte[CFG_DIVSEL_BIT];
      if (wr_cmd & (wbyte == CODE_DISABLE) & ~enable_bit)
         next_active = 1'b0;
      if (active & ~paused & tick)
         next_cnt = 2'(cnt + 1'b1);
      // clear code clears the counter here and the overflow flag below; the divider phase survives
      if (wr_cmd & (wbyte == CODE_CLEAR))
         next_cnt = 2'h0;
      if (~active)
         next_cnt = 2'h0;
      // overflow is taken even if a clear arrives in the same cycle
      if (overflow) begin
         next_ovf_seen = 1'b1;
         if (action)
            next_rst_len = RESET_LEN;
         else
            next_wd_overflow_irq = 1'b1;
      end else if (wr_cmd & (wbyte == CODE_CLEAR)) begin
         next_ovf_seen = 1'b0;
      end
      next_wd_reset_req = (next_rst_len != 5'h00);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div             <= '0;
         cnt             <= 2'h0;
         enable_bit      <= RST_ENABLE;
         period          <= RST_PERIOD;
         action          <= RST_ACTION;
         divsel          <= RST_DIVSEL;
         active          <= RST_ENABLE;
         ovf_seen        <= 1'b0;
         rst_len         <= 5'h00;
         wd_reset_req    <= 1'b0;
         wd_overflow_irq <= 1'b0;
      end else begin
         div             <= next_div;
         cnt             <= next_cnt;
         enable_bit      <= next_enable_bit;
         period          <= next_period;
         action          <= next_action;
         divsel          <= next_divsel;
         active          <= next_active;
         ovf_seen        <= next_ovf_seen;
         rst_len         <= next_rst_len;
         wd_reset_req    <= next_wd_reset_req;
         wd_overflow_irq <= next_wd_overflow_irq;
      end
   end

   // helper: length of the current reset pulse
   logic [5:0] req_run;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         req_run <= 6'h00;
      else if (wd_reset_req)
         req_run <= (req_run == 6'h3F) ? req_run : 6'(req_run + 1'b1);
      else
         req_run <= 6'h00;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_action_once;
      !action |=> !action;
   endproperty
   a_action_once: assert property (p_action_once)
      else $error("action select returned to reset action");

   property p_action_fall;
      $fell(action) |-> $past(wr_ctrl) && !$past(wbyte[CTRL_ACTION_BIT]);
   endproperty
   a_action_fall: assert property (p_action_fall)
      else $error("action select changed without a write of zero");

   property p_disable_cause;
      $fell(active) |-> $past(wr_cmd) && $past(wbyte) == CODE_DISABLE
                        && !$past(enable_bit);
   endproperty
   a_disable_cause: assert property (p_disable_cause)
      else $error("watchdog stopped without a valid disable sequence");

   property p_enable_zero_runs;
      wr_ctrl && !wbyte[CTRL_ENABLE_BIT] && active && !wr_cmd |=> active;
   endproperty
   a_enable_zero_runs: assert property (p_enable_zero_runs)
      else $error("enable bit write alone stopped the watchdog");

   property p_reset_action;
      overflow && action |=> wd_reset_req && !wd_overflow_irq;
   endproperty
   a_reset_action: assert property (p_reset_action)
      else $error("overflow in reset mode gave no reset request");

   property p_irq_action;
      overflow && !action |=> wd_overflow_irq ##1 !wd_overflow_irq;
   endproperty
   a_irq_action: assert property (p_irq_action)
      else $error("overflow in interrupt mode gave no one-cycle interrupt");

   property p_pause_hold;
      paused && active && !wr_cmd |=> cnt == $past(cnt);
   endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("counter moved during a low-power mode");

   property p_clear_keeps_div;
      wr_cmd && wbyte == CODE_CLEAR && !overflow
         |=> cnt == 2'h0 && div == DIV_W'($past(div) + 1'b1);
   endproperty
   a_clear_keeps_div: assert property (p_clear_keeps_div)
      else $error("clear code failed or disturbed the divider");

   property p_disabled_clear;
      !active |=> cnt == 2'h0;
   endproperty
   a_disabled_clear: assert property (p_disabled_clear)
      else $error("counter not held cleared while disabled");

   property p_reset_len;
      req_run <= 6'(RESET_MAX_CLKS);
   endproperty
   a_reset_len: assert property (p_reset_len)
      else $error("reset request held longer than 24 clocks");

   property p_other_code;
      wr_cmd && wbyte != CODE_CLEAR && wbyte != CODE_DISABLE && !wr_ctrl
         |=> active == $past(active);
   endproperty
   a_other_code: assert property (p_other_code)
      else $error("unknown command code changed the enable state");

   property p_wo_read;
      read && ack && (address == ADDR_CTRL_ONE || address == ADDR_COMMAND)
         |-> readdata == 32'h0000_0000;
   endproperty
   a_wo_read: assert property (p_wo_read)
      else $error("write-only register returned data");

endmodule : watchdog_timer_unit
`default_nettype wire
